/* File: hdl/eep_defines.svh */
// Purpose: constants of the serial eeprom target (offsets, fields, counts)
// Assumes: included by bare name from every file that needs it
// Notes:   timing counts are derived from the printed time and the clock rate
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// ----------------------------------------------------------------------
// device address word layout
// ----------------------------------------------------------------------
`define EEP_TYPE_ARRAY     4'ha
`define EEP_TYPE_IDPAGE    4'hb
`define EEP_DEV_TYPE_HI    7
`define EEP_DEV_TYPE_LO    4
`define EEP_DEV_CS_HIGH    3
`define EEP_DEV_CS_LOW     2
`define EEP_DEV_ADDR16     1
`define EEP_DEV_RW         0

// ----------------------------------------------------------------------
// array geometry and word framing
// ----------------------------------------------------------------------
`define EEP_ADDR_W         17
`define EEP_MEM_AW         18
`define EEP_ARRAY_BYTES    131072
`define EEP_ID_BYTES       256
`define EEP_BITS_PER_WORD  4'h8
`define EEP_ID_LOCK_BIT    10
`define EEP_LOCK_DATA_BIT  1
`define EEP_FIFO_DEPTH     32
`define EEP_FIFO_WIDTH     26

// ----------------------------------------------------------------------
// self-timed program cycle
// ----------------------------------------------------------------------
`define EEP_PROG_TIME_MS   5
`define EEP_CLK_MHZ        100
`define EEP_PROG_CYCLES    (`EEP_PROG_TIME_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_BUSY_W         20
`define EEP_PIN_COUNT      5

`endif

/* File: hdl/eep_pkg.sv */
// Purpose: types shared by the serial eeprom target files
// Assumes: constants come from eep_defines.svh
// Notes:   nothing here is imported; users write eep_pkg::name
`include "eep_defines.svh"

package eep_pkg;

  // ----------------------------------------------------------------------
  // protocol states of the target
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADDRH, ST_ADDRL, ST_WDATA, ST_RDATA, ST_RACK, ST_WAIT
  } eep_state_t;

  // one byte on its way to the array: memory index and data
  typedef struct packed {
    logic [`EEP_MEM_AW-1:0] addr;
    logic [7:0]             data;
  } eep_wr_t;

  // synchronised pin bundle, order of the pin vector
  typedef struct packed {
    logic scl;
    logic sda;
    logic cs_high;
    logic cs_low;
    logic guard;
  } eep_pins_t;

  // complete state of the target
  typedef struct packed {
    eep_pins_t               pin_m;     // first synchroniser stage
    eep_pins_t               pin_s;     // second synchroniser stage
    logic                    scl_p;
    logic                    sda_p;
    eep_state_t              st;
    logic [3:0]              cnt;
    logic                    acking;
    logic                    got_ack;
    logic [7:0]              shreg;
    logic [7:0]              txreg;
    logic                    id_sel;
    logic                    rd_dir;
    logic [`EEP_ADDR_W-1:0]  addr;
    logic                    wrote;
    logic                    lock_pend;
    logic                    locked;
    logic                    busy;
    logic [`EEP_BUSY_W-1:0]  busy_cnt;
    logic                    rd_fetch;
    logic                    sda_oe;
    logic                    standby;
  } eep_regs_t;

endpackage : eep_pkg

/* File: hdl/eep_mem.sv */
// Purpose: byte storage for the array and the identification page
// Assumes: one write port and one read port on the system clock
// Notes:   read data come out of a register one cycle after the request
`timescale 1ns/1ns
`include "eep_defines.svh"

module eep_mem (
  input  wire logic                   sys_clk,
  input  wire logic                   ce,
  input  wire logic                   we,
  input  wire eep_pkg::eep_wr_t       wr,
  input  wire logic                   re,
  input  wire logic [`EEP_MEM_AW-1:0] raddr,
  output logic      [7:0]             rdata
);

  logic [7:0] store [0:`EEP_ARRAY_BYTES+`EEP_ID_BYTES-1];

  // ----------------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ce && we) begin
      store[wr.addr] <= wr.data;
    end
    if (ce && re) begin
      rdata <= store[raddr];
    end
  end

endmodule : eep_mem

/* File: hdl/eep_fifo.sv */
// Purpose: byte queue between the serial receiver and the array
// Assumes: both sides on the system clock
// Notes:   full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ns

module eep_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] slots [0:DEPTH-1];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;

  // ----------------------------------------------------------------------
  // status and head word
  // ----------------------------------------------------------------------
  assign out_valid = (wptr_reg != rptr_reg);
  assign in_ready  = !((wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
  assign out_data  = slots[rptr_reg[AW-1:0]];

  // pointer update, stalls when the drain side is not ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (ce) begin
      if (in_valid && in_ready) begin
        slots[wptr_reg[AW-1:0]] <= in_data;
        wptr_reg                <= wptr_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

endmodule : eep_fifo

/* File: hdl/eep_target.sv */
// Purpose: two-wire serial target of a 128-Kbyte eeprom with an id page
// Assumes: sys_clk far faster than the serial clock; all pins asynchronous
// Notes:   no clock stretching; the serial clock is sampled, never used
`timescale 1ns/1ns
`include "eep_defines.svh"

module eep_target #(
  parameter int PROG_CYCLES = `EEP_PROG_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_strap_high,
  input  wire logic chip_select_strap_low,
  input  wire logic write_guard,
  output logic      busy,
  output logic      standby,
  output logic      id_locked
);

  eep_pkg::eep_regs_t r_reg;
  eep_pkg::eep_regs_t r_next;
  eep_pkg::eep_wr_t   push_word;
  eep_pkg::eep_wr_t   drain_word;
  logic                    push;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    drain_ready;
  logic [7:0]              rd_byte;
  logic [`EEP_MEM_AW-1:0]  rd_index;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;
  logic                    ack_ok;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // memory index of an array byte or of an id page byte
  function automatic logic [`EEP_MEM_AW-1:0] mem_index(
    input logic                   id,
    input logic [`EEP_ADDR_W-1:0] a
  );
    if (id) begin
      mem_index = {1'b1, 9'h000, a[7:0]};
    end else begin
      mem_index = {1'b0, a};
    end
  endfunction : mem_index

  // read address after a byte: id page wraps in its page, array over all
  function automatic logic [`EEP_ADDR_W-1:0] rd_next(
    input logic                   id,
    input logic [`EEP_ADDR_W-1:0] a
  );
    if (id) begin
      rd_next = {a[16:8], a[7:0] + 8'h01};
    end else begin
      rd_next = a + 17'h00001;
    end
  endfunction : rd_next

  // ----------------------------------------------------------------------
  // bus events from the synchronised pins
  // ----------------------------------------------------------------------

  // edges and conditions, all on second-stage samples only
  always_comb begin
    scl_rise  = r_reg.pin_s.scl && !r_reg.scl_p;
    scl_fall  = !r_reg.pin_s.scl && r_reg.scl_p;
    bus_start = r_reg.pin_s.scl && r_reg.scl_p
                && r_reg.sda_p && !r_reg.pin_s.sda;
    bus_stop  = r_reg.pin_s.scl && r_reg.scl_p
                && !r_reg.sda_p && r_reg.pin_s.sda;
  end

  // queue word for the byte just received, at the pre-increment address
  always_comb begin
    push_word.addr = mem_index(r_reg.id_sel, r_reg.addr);
    push_word.data = r_reg.shreg;
    rd_index       = mem_index(r_reg.id_sel, r_reg.addr);
    drain_ready    = !r_reg.rd_fetch;  // reads win the array port
  end

  // ----------------------------------------------------------------------
  // next state of the target
  // ----------------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    push            = 1'b0;
    ack_ok          = 1'b0;
    r_next.rd_fetch = 1'b0;

    // two flip-flops on every pin, then edge history
    r_next.pin_m = '{scl: scl_in, sda: sda_in, cs_high: chip_select_strap_high,
                     cs_low: chip_select_strap_low, guard: write_guard};
    r_next.pin_s = r_reg.pin_m;
    r_next.scl_p = r_reg.pin_s.scl;
    r_next.sda_p = r_reg.pin_s.sda;

    // self-timed program cycle countdown
    if (r_reg.busy) begin
      if (r_reg.busy_cnt <= `EEP_BUSY_W'(1)) begin
        r_next.busy     = 1'b0;
        r_next.busy_cnt = '0;
      end else begin
        r_next.busy_cnt = r_reg.busy_cnt - `EEP_BUSY_W'(1);
      end
    end

    if (bus_start) begin
      // any start, repeated or not, opens a device word
      r_next.st        = eep_pkg::ST_DEV;
      r_next.cnt       = 4'h0;
      r_next.acking    = 1'b0;
      r_next.sda_oe    = 1'b0;
      r_next.wrote     = 1'b0;
      r_next.lock_pend = 1'b0;
    end else if (bus_stop) begin
      // a stop in ST_WDATA after queued write data or an armed id lock starts the program cycle
      if (r_reg.st == eep_pkg::ST_WDATA && (r_reg.wrote || r_reg.lock_pend)) begin
        r_next.busy     = 1'b1;
        r_next.busy_cnt = `EEP_BUSY_W'(PROG_CYCLES);
        if (r_reg.lock_pend) begin
          r_next.locked = 1'b1;
        end
      end
      r_next.st        = eep_pkg::ST_IDLE;
      r_next.sda_oe    = 1'b0;
      r_next.acking    = 1'b0;
      r_next.wrote     = 1'b0;
      r_next.lock_pend = 1'b0;
    end else begin
      case (r_reg.st)
        eep_pkg::ST_DEV, eep_pkg::ST_ADDRH, eep_pkg::ST_ADDRL, eep_pkg::ST_WDATA: begin
          if (scl_rise && !r_reg.acking && r_reg.cnt < `EEP_BITS_PER_WORD) begin
            // shift in one bit, msb first
            r_next.shreg = {r_reg.shreg[6:0], r_reg.pin_s.sda};
            r_next.cnt   = r_reg.cnt + 4'h1;
          end else if (scl_fall && !r_reg.acking && r_reg.cnt == `EEP_BITS_PER_WORD) begin
            // eighth bit in: decide the acknowledge for the ninth clock
            case (r_reg.st)
              eep_pkg::ST_DEV: begin
                ack_ok = (r_reg.shreg[`EEP_DEV_TYPE_HI:`EEP_DEV_TYPE_LO] == `EEP_TYPE_ARRAY
                          || r_reg.shreg[`EEP_DEV_TYPE_HI:`EEP_DEV_TYPE_LO]
                             == `EEP_TYPE_IDPAGE)
                         && r_reg.shreg[`EEP_DEV_CS_HIGH] == r_reg.pin_s.cs_high
                         && r_reg.shreg[`EEP_DEV_CS_LOW] == r_reg.pin_s.cs_low
                         && !r_reg.busy;
                r_next.id_sel = (r_reg.shreg[`EEP_DEV_TYPE_HI:`EEP_DEV_TYPE_LO]
                                 == `EEP_TYPE_IDPAGE);
                r_next.rd_dir = r_reg.shreg[`EEP_DEV_RW];
                if (ack_ok && !r_reg.shreg[`EEP_DEV_RW]) begin
                  r_next.addr[16] = r_reg.shreg[`EEP_DEV_ADDR16];
                end
                // a read header fetches the byte at the address counter
                r_next.rd_fetch = ack_ok && r_reg.shreg[`EEP_DEV_RW];
              end
              eep_pkg::ST_ADDRH: begin
                ack_ok           = 1'b1;
                r_next.addr[15:8] = r_reg.shreg;
              end
              eep_pkg::ST_ADDRL: begin
                ack_ok          = 1'b1;
                r_next.addr[7:0] = r_reg.shreg;
              end
              default: begin
                if (r_reg.id_sel && r_reg.addr[`EEP_ID_LOCK_BIT]) begin
                  // id lock command, armed by data bit 1
                  ack_ok = 1'b1;
                  if (r_reg.shreg[`EEP_LOCK_DATA_BIT]) begin
                    r_next.lock_pend = 1'b1;
                  end
                end else if (r_reg.id_sel && r_reg.locked) begin
                  ack_ok = 1'b0;
                end else if (!fifo_in_ready) begin
                  ack_ok = 1'b0;  // queue full, byte refused
                end else begin
                  ack_ok = 1'b1;
                  if (!(r_reg.pin_s.guard && !r_reg.id_sel)) begin
                    push         = 1'b1;
                    r_next.wrote = 1'b1;
                  end  // guarded: acknowledged, nothing programmed
                  r_next.addr[7:0] = r_reg.addr[7:0] + 8'h01;
                end
              end
            endcase
            r_next.acking  = 1'b1;
            r_next.got_ack = ack_ok;
            r_next.sda_oe  = ack_ok;
          end else if (scl_fall && r_reg.acking) begin
            // end of the ninth clock: release and move on
            r_next.acking = 1'b0;
            r_next.sda_oe = 1'b0;
            r_next.cnt    = 4'h0;
            if (!r_reg.got_ack) begin
              r_next.st = eep_pkg::ST_WAIT;
            end else begin
              case (r_reg.st)
                eep_pkg::ST_DEV: begin
                  if (r_reg.rd_dir) begin
                    // first read byte goes out on this same falling edge
                    r_next.st     = eep_pkg::ST_RDATA;
                    r_next.txreg  = rd_byte;
                    r_next.sda_oe = !rd_byte[7];
                    r_next.cnt    = 4'h1;
                    r_next.addr   = rd_next(r_reg.id_sel, r_reg.addr);
                  end else begin
                    r_next.st = eep_pkg::ST_ADDRH;
                  end
                end
                eep_pkg::ST_ADDRH: r_next.st = eep_pkg::ST_ADDRL;
                eep_pkg::ST_ADDRL: r_next.st = eep_pkg::ST_WDATA;
                default:           r_next.st = eep_pkg::ST_WDATA;
              endcase
            end
          end
        end
        eep_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (r_reg.cnt < `EEP_BITS_PER_WORD) begin
              // next bit onto the line, open drain: drive only a zero
              r_next.txreg  = {r_reg.txreg[6:0], 1'b0};
              r_next.sda_oe = !r_reg.txreg[6];
              r_next.cnt    = r_reg.cnt + 4'h1;
            end else begin
              // release for the master's acknowledge
              r_next.sda_oe = 1'b0;
              r_next.st     = eep_pkg::ST_RACK;
              r_next.cnt    = 4'h0;
            end
          end
        end
        eep_pkg::ST_RACK: begin
          if (scl_rise && r_reg.cnt == 4'h0) begin
            r_next.got_ack  = !r_reg.pin_s.sda;
            r_next.rd_fetch = !r_reg.pin_s.sda;
            r_next.cnt      = 4'h1;
          end else if (scl_fall && r_reg.cnt == 4'h1) begin
            if (r_reg.got_ack) begin
              r_next.st     = eep_pkg::ST_RDATA;
              r_next.txreg  = rd_byte;
              r_next.sda_oe = !rd_byte[7];
              r_next.cnt    = 4'h1;
              r_next.addr   = rd_next(r_reg.id_sel, r_reg.addr);
            end else begin
              r_next.st = eep_pkg::ST_WAIT;
            end
          end
        end
        default: begin
          // idle or waiting: line released, only start and stop matter
          r_next.sda_oe = 1'b0;
        end
      endcase
    end

    // standby once idle and no program cycle is running
    r_next.standby = (r_next.st == eep_pkg::ST_IDLE) && !r_next.busy;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_reg         <= '0;
      r_reg.st      <= eep_pkg::ST_IDLE;
      r_reg.standby <= 1'b1;
      // clock and data pins and edge history start at the idle-high bus level: no false edge
      r_reg.pin_m.scl <= 1'b1;
      r_reg.pin_m.sda <= 1'b1;
      r_reg.pin_s.scl <= 1'b1;
      r_reg.pin_s.sda <= 1'b1;
      r_reg.scl_p     <= 1'b1;
      r_reg.sda_p     <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops except the constant sda_out
  // ----------------------------------------------------------------------
  assign sda_out   = 1'b0;  // constant low, driven only through sda_oe
  assign sda_oe    = r_reg.sda_oe;
  assign busy      = r_reg.busy;
  assign standby   = r_reg.standby;
  assign id_locked = r_reg.locked;

  // ----------------------------------------------------------------------
  // byte queue and storage
  // ----------------------------------------------------------------------
  eep_fifo #(
    .W     (`EEP_FIFO_WIDTH),
    .DEPTH (`EEP_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push),
    .in_data   (push_word),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (drain_word),
    .out_ready (drain_ready)
  );

  eep_mem u_mem (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (fifo_out_valid && drain_ready),
    .wr      (drain_word),
    .re      (r_reg.rd_fetch),
    .raddr   (rd_index),
    .rdata   (rd_byte)
  );

endmodule : eep_target

/* File: dv/eep_target_assertions.sv */
// Purpose: pin checks of the serial eeprom target
// Assumes: synchronous reset; program cycles counted only while ce is high
// Notes:   bound into every eep_target
`timescale 1ns/1ns
module eep_target_chk #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic busy,
  input wire logic standby,
  input wire logic id_locked
);
  int busy_len_reg;
  int busy_len_next;
  // length of the running program cycle, in enabled cycles
  always_comb busy_len_next = busy ? busy_len_reg + (ce ? 1 : 0) : 0;
  always_ff @(posedge sys_clk) busy_len_reg <= rst ? 0 : busy_len_next;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_hold; sda_oe[*8]; endsequence
  property p_rst_idle; $fell(rst) |-> standby && !busy && !sda_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle");
  property p_quiet; busy |-> !standby && !sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("answer while busy");
  property p_len; $fell(busy) |-> busy_len_reg == PROG_CYCLES; endproperty
  a_len: assert property (p_len) else $error("program cycle length");
  property p_back; $fell(busy) |-> standby; endproperty
  a_back: assert property (p_back) else $error("no standby");
  property p_stop; $rose(busy) |-> scl_in; endproperty
  a_stop: assert property (p_stop) else $error("busy off stop");
  property p_hold; $rose(sda_oe) |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("short drive");
  property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
  a_edge: assert property (p_edge) else $error("drive change clock high");
  property p_keep; !$fell(id_locked); endproperty
  a_keep: assert property (p_keep) else $error("lock lost");
  property p_lock; $rose(id_locked) |-> scl_in; endproperty
  a_lock: assert property (p_lock) else $error("lock off stop");
endmodule : eep_target_chk

bind eep_target eep_target_chk #(.PROG_CYCLES(PROG_CYCLES)) i_eep_target_chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_oe(sda_oe),
  .busy(busy), .standby(standby), .id_locked(id_locked));

/* File: dv/eep_bm.sv */
// Purpose: two-wire bus master facing the target
// Assumes: clock half period of 8 sys_clk
// Notes:   line pulled high when nobody drives
`timescale 1ns/1ns
module eep_bm (
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_drv,
  output logic      line
);
  // wired data line with pull-up
  assign line = sda_drv & ~sda_oe;
  // bus idle high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic start();
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(8);
  endtask : stop
  // eight bits msb first, then the ninth
  task automatic xfer(input logic [7:0] b, input logic a9,
                      output logic [7:0] r, output logic a);
    logic [8:0] o;
    logic [8:0] s;
    o = {b, a9};
    for (int i = 8; i >= 0; i--) begin
      tick(4);
      sda_drv <= o[i];
      tick(4);
      scl <= 1'b1;
      tick(4);
      @(negedge sys_clk);
      s = {s[7:0], line};
      tick(4);
      scl <= 1'b0;
    end
    r = s[8:1];
    a = s[0];
  endtask : xfer
  // bus recovery: nine clocks with data released high, caller then starts
  task automatic recover();
    tick(4);
    sda_drv <= 1'b1;
    repeat (9) begin
      tick(8);
      scl <= 1'b1;
      tick(8);
      scl <= 1'b0;
    end
  endtask : recover
endmodule : eep_bm

/* File: dv/test_eep_target.sv */
// Purpose: self-checking bench of the serial eeprom target
// Assumes: bus master model drives the serial pins
// Notes:   short program cycle of 200 clocks
`timescale 1ns/1ns
module test_eep_target;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_drv, line, sda_oe, busy, standby, id_locked;
  logic cs_high;
  logic cs_low;
  logic guard;
  logic ce;
  int n_errors = 0;
  int n_compared = 0;
  // straps, device word, expected ninth bit
  logic [10:0] rows [6] = '{11'h140, 11'h550, 11'h348, 11'h151, 11'h181, 11'h160};
  eep_target #(.PROG_CYCLES(200)) i_eep_target (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(line),
    .sda_out(), .sda_oe(sda_oe), .chip_select_strap_high(cs_high),
    .chip_select_strap_low(cs_low), .write_guard(guard), .busy(busy),
    .standby(standby), .id_locked(id_locked));
  eep_bm i_eep_bm (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
    .sda_drv(sda_drv), .line(line));
  always #5 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] b, input logic nack);
    logic [7:0] r;
    logic a;
    i_eep_bm.xfer(b, 1'b1, r, a);
    check({7'h00, a}, {7'h00, nack});
  endtask : send
  task automatic head(input logic [7:0] dev, input logic [15:0] a);
    i_eep_bm.start();
    send(dev, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
  endtask : head
  task automatic wr(input logic [7:0] dev, input logic [15:0] a, input logic [7:0] d);
    head(dev, a);
    send(d, 1'b0);
    i_eep_bm.stop();
  endtask : wr
  task automatic rd(input logic [7:0] dev, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic x;
    head(dev, a);
    i_eep_bm.start();
    send(dev | 8'h01, 1'b0);
    i_eep_bm.xfer(8'hff, 1'b1, r, x);
    check(r, exp);
    i_eep_bm.stop();
  endtask : rd
  task automatic settle();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) i_eep_bm.tick(1);
    if (busy !== 1'b0) begin
      n_errors++;
      $display("mismatch at %0t: program cycle never ended", $time);
    end
  endtask : settle
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // watchdog, about three times the expected run
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  // main sequence
  initial begin
    logic [7:0] r;
    logic x;
    {ce, cs_high, cs_low, guard} <= 4'h8;
    i_eep_bm.tick(10);
    rst <= 1'b0;
    i_eep_bm.tick(4);
    check({5'h00, busy, standby, sda_oe}, 8'h02);
    for (int i = 0; i < 6; i++) begin
      {cs_high, cs_low} <= rows[i][10:9];
      i_eep_bm.tick(8);
      i_eep_bm.start();
      send(rows[i][8:1], rows[i][0]);
      i_eep_bm.stop();
      settle();
    end
    {cs_high, cs_low} <= 2'b00;
    $display("address rows done");
    head(8'ha2, 16'h00ff);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    i_eep_bm.stop();
    check({6'h00, busy, standby}, 8'h02);
    i_eep_bm.start();
    send(8'ha2, 1'b1);
    i_eep_bm.stop();
    settle();
    rd(8'ha2, 16'h00ff, 8'h11);
    rd(8'ha2, 16'h0000, 8'h22);
    $display("page write done");
    wr(8'ha0, 16'h0010, 8'h3c);
    settle();
    guard <= 1'b1;
    wr(8'ha0, 16'h0010, 8'h5a);
    check({7'h00, busy}, 8'h00);
    guard <= 1'b0;
    i_eep_bm.start();
    i_eep_bm.recover();
    rd(8'ha0, 16'h0010, 8'h3c);
    $display("guard done");
    wr(8'ha2, 16'hffff, 8'h5e);
    settle();
    wr(8'ha0, 16'h0000, 8'h6f);
    ce <= 1'b0;
    i_eep_bm.tick(300);
    check({6'h00, busy, standby}, 8'h02);
    ce <= 1'b1;
    settle();
    head(8'ha2, 16'hffff);
    i_eep_bm.start();
    send(8'ha3, 1'b0);
    i_eep_bm.xfer(8'hff, 1'b0, r, x);
    check(r, 8'h5e);
    i_eep_bm.xfer(8'hff, 1'b1, r, x);
    check(r, 8'h6f);
    i_eep_bm.stop();
    $display("sequential read done");
    wr(8'hb0, 16'hfb10, 8'h77);
    settle();
    rd(8'hb0, 16'h0010, 8'h77);
    wr(8'hb0, 16'h0400, 8'h02);
    settle();
    check({7'h00, id_locked}, 8'h01);
    head(8'hb0, 16'h0010);
    send(8'h99, 1'b1);
    i_eep_bm.stop();
    settle();
    rd(8'hb0, 16'h0010, 8'h77);
    $display("id page done");
    close_out();
  end
endmodule : test_eep_target
